/* File: rtl/stcr_regs.vh */
// Offsets, field positions, reset values and event bits of the secure top config block
`ifndef STCR_REGS_VH
`define STCR_REGS_VH

// --------------------------------------------------------------------------
// Register byte offsets
// --------------------------------------------------------------------------
`define STCR_OFS_CONFIG 6'h00
`define STCR_OFS_EVT_STATUS 6'h04
`define STCR_OFS_EVT_MASK 6'h08
`define STCR_OFS_REDIRECT 6'h0c

// --------------------------------------------------------------------------
// Configuration register fields
// --------------------------------------------------------------------------
`define STCR_BIT_COMP_OWNER 29
`define STCR_BIT_CFG_ROUTE_NS 28
`define STCR_BIT_PERF_EN 27
`define STCR_BIT_FETCH_GUARD 26
`define STCR_BIT_EXT_FORCE_SEC 25
`define STCR_BIT_GS_SEC_ONLY 24
`define STCR_IRQ_OVR_HI 23
`define STCR_IRQ_OVR_LO 16

// Redirect control register fields
`define STCR_BIT_CFG_REDIRECT 0
`define STCR_BIT_EXT_REDIRECT 1

// --------------------------------------------------------------------------
// Reset values
// --------------------------------------------------------------------------
`define STCR_RST_BIT 1'b0
`define STCR_RST_EVT 7'h00
`define STCR_RST_REDIRECT 2'h0

// --------------------------------------------------------------------------
// Event bits of status and mask
// --------------------------------------------------------------------------
`define STCR_EVT_W 7
`define STCR_EVT_CFG_SEC 0
`define STCR_EVT_CFG_NS 1
`define STCR_EVT_CFG_SHARED 2
`define STCR_EVT_EXT_SHARED 3
`define STCR_EVT_EXT_SEC 4
`define STCR_EVT_FETCH_CB 5
`define STCR_EVT_FETCH_SEC 6

// --------------------------------------------------------------------------
// Bus answers and identification range
// --------------------------------------------------------------------------
`define STCR_RESP_OKAY 2'h0
`define STCR_RESP_SLVERR 2'h2
`define STCR_RESP_DECERR 2'h3
`define STCR_ID_RANGE_LO 12'hfd0
`define STCR_ID_RANGE_HI 12'hffc

`endif

/* File: rtl/stcr_top.v */
// Secure top configuration register with fault routing, behind an AXI4-Lite slave
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`include "stcr_regs.vh"

// Functional notes
// - Bit 29 gives compressed index to Secure
// - No compressed indexing: bit 29 reads zero
// - Bit 28 routes NS-to-Secure config faults
// - Config redirect sends Secure-bound faults to shared
// - Route bit resets zero, fixed or absent
// - Route bit ignores common or NS targets
// - Bit 27 lets Secure events be counted
// - Bit 26 faults Secure fetch leaving NS
// - Fetch fault to context bank else Secure
// - Bit 25 forces external faults to Secure
// - External redirect moves shared faults to Secure
// - Bit 24 makes global space Secure-only
// - ID range coverage chosen by parameter
// - Bits 23:16 NS interrupt count override
// - Override may be read-only without Secure contexts
// - Register exists with two states, Secure only
module stcr_top #(
  parameter TWO_SEC_STATES = 1,
  parameter HAS_COMP_INDEX = 1,
  parameter CAN_CFG_FAULT = 1,
  parameter CFG_ROUTE_FIXED = 0,
  parameter [0:0] CFG_ROUTE_FIXED_VAL = 1'b0,
  parameter HAS_SECURE_CTX = 1,
  parameter GS_COVERS_ID = 1,
  parameter [7:0] NUM_IRQ = 8'h10,
  parameter [7:0] IRQ_OVR_IMPL = 8'h1f
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire awvalid,
  output wire awready,
  input wire [5:0] awaddr,
  input wire [2:0] awprot,
  // AXI4-Lite write data
  input wire wvalid,
  output wire wready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  // AXI4-Lite write response
  output reg bvalid,
  input wire bready,
  output reg [1:0] bresp,
  // AXI4-Lite read address
  input wire arvalid,
  output wire arready,
  input wire [5:0] araddr,
  input wire [2:0] arprot,
  // AXI4-Lite read data
  output reg rvalid,
  input wire rready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  // Interrupt
  output wire irq,
  // Control levels
  output wire compressed_index_secure_owner,
  output wire cfg_fault_route_nonsecure,
  output reg secure_perf_count_enable,
  output reg secure_fetch_guard,
  output reg external_fault_force_secure,
  output reg global_space_secure_only,
  output wire [7:0] nonsecure_irq_count_override,
  // Configuration access fault in
  input wire cfg_fault_valid,
  input wire cfg_fault_target_secure,
  // Configuration access fault routing out
  output reg cfg_fault_to_secure,
  output reg cfg_fault_to_nonsecure,
  output reg cfg_fault_to_shared,
  // External fault in and routing out
  input wire ext_fault_valid,
  output reg ext_fault_to_shared,
  output reg ext_fault_to_secure,
  // Instruction fetch check
  input wire fetch_valid,
  input wire fetch_secure_domain,
  input wire fetch_instr,
  input wire fetch_out_nonsecure,
  input wire fetch_has_cb,
  output reg fetch_perm_fault,
  output reg fetch_fault_to_cb,
  output reg fetch_fault_to_secure,
  // Performance event gate
  input wire perf_event_valid,
  input wire perf_event_secure,
  output reg perf_count_pulse,
  // Global space access check
  input wire gs_check_valid,
  input wire gs_check_secure,
  input wire gs_check_s2_cb,
  input wire [11:0] gs_check_offset,
  output reg gs_check_done,
  output reg gs_check_allow
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function [31:0] strb_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] strb;
    integer i;
    begin
      strb_merge = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          strb_merge[i*8 +: 8] = new_val[i*8 +: 8];
        end
      end
    end
  endfunction

  function is_mapped;
    input [5:0] addr;
    begin
      case (addr)
        `STCR_OFS_CONFIG: is_mapped = (TWO_SEC_STATES != 0);
        `STCR_OFS_EVT_STATUS: is_mapped = 1'b1;
        `STCR_OFS_EVT_MASK: is_mapped = 1'b1;
        `STCR_OFS_REDIRECT: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg comp_owner;
  reg cfg_route_q;
  reg [7:0] irq_ovr_q;
  reg [`STCR_EVT_W-1:0] evt_status;
  reg [`STCR_EVT_W-1:0] evt_mask;
  reg [1:0] redirect;
  reg aw_have;
  reg w_have;
  reg [5:0] aw_addr_q;
  reg aw_nonsec;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;

  wire [31:0] cfg_rd;
  wire [31:0] wr_cfg;
  wire [31:0] wr_stat;
  wire [31:0] wr_mask;
  wire [31:0] wr_redir;
  wire do_write;
  wire wr_ok;
  wire rd_take;
  wire rd_nonsec;
  wire bus_cfg_fault;
  wire any_cfg_fault;
  wire any_cfg_target_sec;
  wire fetch_bad;
  wire id_range;
  reg [`STCR_EVT_W-1:0] evt_set;

  // --------------------------------------------------------------------------
  // Control field views
  // --------------------------------------------------------------------------
  assign compressed_index_secure_owner = (HAS_COMP_INDEX != 0) ? comp_owner : 1'b0;
  assign cfg_fault_route_nonsecure = (CAN_CFG_FAULT == 0) ? 1'b0 :
    (CFG_ROUTE_FIXED != 0) ? CFG_ROUTE_FIXED_VAL : cfg_route_q;
  assign nonsecure_irq_count_override = (HAS_SECURE_CTX != 0) ?
    (irq_ovr_q & IRQ_OVR_IMPL) : NUM_IRQ;

  assign cfg_rd = {2'h0,
    compressed_index_secure_owner,
    cfg_fault_route_nonsecure,
    secure_perf_count_enable,
    secure_fetch_guard,
    external_fault_force_secure,
    global_space_secure_only,
    nonsecure_irq_count_override,
    16'h0000};

  // --------------------------------------------------------------------------
  // AXI4-Lite write path
  // --------------------------------------------------------------------------
  assign awready = !aw_have && !bvalid;
  assign wready = !w_have && !bvalid;
  assign do_write = aw_have && w_have && !bvalid;
  assign wr_ok = do_write && !aw_nonsec && is_mapped(aw_addr_q);
  assign wr_cfg = strb_merge(cfg_rd, w_data_q, w_strb_q);
  assign wr_stat = strb_merge(32'h00000000, w_data_q, w_strb_q);
  assign wr_mask = strb_merge({25'h0000000, evt_mask}, w_data_q, w_strb_q);
  assign wr_redir = strb_merge({30'h00000000, redirect}, w_data_q, w_strb_q);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr_q <= 6'h00;
      aw_nonsec <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `STCR_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_have <= 1'b1;
        aw_addr_q <= awaddr;
        aw_nonsec <= awprot[1];
      end
      if (wvalid && wready) begin
        w_have <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (do_write) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        bvalid <= 1'b1;
        if (!is_mapped(aw_addr_q)) begin
          bresp <= `STCR_RESP_DECERR;
        end else if (aw_nonsec) begin
          bresp <= `STCR_RESP_SLVERR;
        end else begin
          bresp <= `STCR_RESP_OKAY;
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite read path
  // --------------------------------------------------------------------------
  assign arready = !rvalid;
  assign rd_take = arvalid && arready;
  assign rd_nonsec = arprot[1];

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `STCR_RESP_OKAY;
    end else if (rd_take) begin
      rvalid <= 1'b1;
      rdata <= 32'h00000000;
      if (!is_mapped(araddr)) begin
        rresp <= `STCR_RESP_DECERR;
      end else if (rd_nonsec) begin
        rresp <= `STCR_RESP_SLVERR;
      end else begin
        rresp <= `STCR_RESP_OKAY;
        case (araddr)
          `STCR_OFS_CONFIG: rdata <= cfg_rd;
          `STCR_OFS_EVT_STATUS: rdata <= {25'h0000000, evt_status};
          `STCR_OFS_EVT_MASK: rdata <= {25'h0000000, evt_mask};
          `STCR_OFS_REDIRECT: rdata <= {30'h00000000, redirect};
          default: rdata <= 32'h00000000;
        endcase
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      comp_owner <= `STCR_RST_BIT;
      cfg_route_q <= `STCR_RST_BIT;
      secure_perf_count_enable <= `STCR_RST_BIT;
      secure_fetch_guard <= `STCR_RST_BIT;
      external_fault_force_secure <= `STCR_RST_BIT;
      global_space_secure_only <= `STCR_RST_BIT;
      irq_ovr_q <= NUM_IRQ;
      evt_mask <= `STCR_RST_EVT;
      redirect <= `STCR_RST_REDIRECT;
    end else if (wr_ok) begin
      case (aw_addr_q)
        `STCR_OFS_CONFIG: begin
          comp_owner <= wr_cfg[`STCR_BIT_COMP_OWNER];
          cfg_route_q <= wr_cfg[`STCR_BIT_CFG_ROUTE_NS];
          secure_perf_count_enable <= wr_cfg[`STCR_BIT_PERF_EN];
          secure_fetch_guard <= wr_cfg[`STCR_BIT_FETCH_GUARD];
          external_fault_force_secure <= wr_cfg[`STCR_BIT_EXT_FORCE_SEC];
          global_space_secure_only <= wr_cfg[`STCR_BIT_GS_SEC_ONLY];
          irq_ovr_q <= wr_cfg[`STCR_IRQ_OVR_HI:`STCR_IRQ_OVR_LO] & IRQ_OVR_IMPL;
        end
        `STCR_OFS_EVT_MASK: evt_mask <= wr_mask[`STCR_EVT_W-1:0];
        `STCR_OFS_REDIRECT: redirect <= wr_redir[1:0];
        default: begin
          comp_owner <= comp_owner;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Fault routing
  // --------------------------------------------------------------------------
  // A refused Non-secure bus access is itself a fault on a Secure register
  assign bus_cfg_fault = (do_write && aw_nonsec && is_mapped(aw_addr_q)) ||
    (rd_take && rd_nonsec && is_mapped(araddr));
  assign any_cfg_fault = (CAN_CFG_FAULT != 0) && (cfg_fault_valid || bus_cfg_fault);
  assign any_cfg_target_sec = bus_cfg_fault || cfg_fault_target_secure;
  assign fetch_bad = fetch_valid && secure_fetch_guard && fetch_secure_domain &&
    fetch_instr && fetch_out_nonsecure;
  assign id_range = (gs_check_offset >= `STCR_ID_RANGE_LO) &&
    (gs_check_offset <= `STCR_ID_RANGE_HI);

  always @* begin
    evt_set = `STCR_RST_EVT;
    if (any_cfg_fault) begin
      if (!any_cfg_target_sec) begin
        evt_set[`STCR_EVT_CFG_NS] = 1'b1;
      end else if (cfg_fault_route_nonsecure) begin
        evt_set[`STCR_EVT_CFG_NS] = 1'b1;
      end else if (redirect[`STCR_BIT_CFG_REDIRECT]) begin
        evt_set[`STCR_EVT_CFG_SHARED] = 1'b1;
      end else begin
        evt_set[`STCR_EVT_CFG_SEC] = 1'b1;
      end
    end
    if (ext_fault_valid) begin
      if (external_fault_force_secure || redirect[`STCR_BIT_EXT_REDIRECT]) begin
        evt_set[`STCR_EVT_EXT_SEC] = 1'b1;
      end else begin
        evt_set[`STCR_EVT_EXT_SHARED] = 1'b1;
      end
    end
    if (fetch_bad) begin
      if (fetch_has_cb) begin
        evt_set[`STCR_EVT_FETCH_CB] = 1'b1;
      end else begin
        evt_set[`STCR_EVT_FETCH_SEC] = 1'b1;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      cfg_fault_to_secure <= 1'b0;
      cfg_fault_to_nonsecure <= 1'b0;
      cfg_fault_to_shared <= 1'b0;
      ext_fault_to_shared <= 1'b0;
      ext_fault_to_secure <= 1'b0;
      fetch_perm_fault <= 1'b0;
      fetch_fault_to_cb <= 1'b0;
      fetch_fault_to_secure <= 1'b0;
      perf_count_pulse <= 1'b0;
      gs_check_done <= 1'b0;
      gs_check_allow <= 1'b0;
    end else begin
      cfg_fault_to_secure <= evt_set[`STCR_EVT_CFG_SEC];
      cfg_fault_to_nonsecure <= evt_set[`STCR_EVT_CFG_NS];
      cfg_fault_to_shared <= evt_set[`STCR_EVT_CFG_SHARED];
      ext_fault_to_shared <= evt_set[`STCR_EVT_EXT_SHARED];
      ext_fault_to_secure <= evt_set[`STCR_EVT_EXT_SEC];
      fetch_perm_fault <= fetch_bad;
      fetch_fault_to_cb <= evt_set[`STCR_EVT_FETCH_CB];
      fetch_fault_to_secure <= evt_set[`STCR_EVT_FETCH_SEC];
      perf_count_pulse <= perf_event_valid &&
        (!perf_event_secure || secure_perf_count_enable);
      gs_check_done <= gs_check_valid;
      if (gs_check_secure || !global_space_secure_only) begin
        gs_check_allow <= gs_check_valid;
      end else if (id_range && (GS_COVERS_ID == 0) && !gs_check_s2_cb) begin
        gs_check_allow <= gs_check_valid;
      end else begin
        gs_check_allow <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Event status and interrupt
  // --------------------------------------------------------------------------
  // New events win over a write-one-to-clear in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      evt_status <= `STCR_RST_EVT;
    end else if (wr_ok && (aw_addr_q == `STCR_OFS_EVT_STATUS)) begin
      evt_status <= (evt_status & ~wr_stat[`STCR_EVT_W-1:0]) | evt_set;
    end else begin
      evt_status <= evt_status | evt_set;
    end
  end

  assign irq = |(evt_status & evt_mask);

endmodule // stcr_top

/* File: tb/stcr_top_asserts.sv */
// Port-level assertions and covers for the secure top configuration register
module stcr_asserts #(
  parameter [7:0] IRQ_OVR_IMPL = 8'h1f
) (
  // Watched ports
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [5:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic rvalid,
  input wire logic [1:0] rresp,
  input wire logic cfg_fault_valid,
  input wire logic cfg_fault_target_secure,
  input wire logic cfg_fault_route_nonsecure,
  input wire logic cfg_fault_to_secure,
  input wire logic cfg_fault_to_nonsecure,
  input wire logic ext_fault_valid,
  input wire logic external_fault_force_secure,
  input wire logic ext_fault_to_shared,
  input wire logic ext_fault_to_secure,
  input wire logic perf_event_valid,
  input wire logic perf_event_secure,
  input wire logic secure_perf_count_enable,
  input wire logic perf_count_pulse,
  input wire logic secure_fetch_guard,
  input wire logic fetch_perm_fault,
  input wire logic gs_check_valid,
  input wire logic gs_check_secure,
  input wire logic global_space_secure_only,
  input wire logic gs_check_done,
  input wire logic gs_check_allow,
  input wire logic [7:0] nonsecure_irq_count_override
);
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_ext_force_secure: assert property (
    ext_fault_valid && external_fault_force_secure |=> ext_fault_to_secure && !ext_fault_to_shared)
    else $error("external fault not forced to secure");
  a_ext_shared_cause: assert property (
    ext_fault_to_shared |-> $past(ext_fault_valid) && !$past(external_fault_force_secure))
    else $error("external fault wrongly reported shared");
  a_cfg_common_ns: assert property (
    cfg_fault_valid && !cfg_fault_target_secure |=> cfg_fault_to_nonsecure)
    else $error("common target fault not nonsecure");
  a_cfg_route_ns: assert property (
    cfg_fault_valid && cfg_fault_target_secure && cfg_fault_route_nonsecure
    |=> cfg_fault_to_nonsecure && !cfg_fault_to_secure) else $error("cfg fault misrouted");
  a_perf_gate: assert property (
    $past(aresetn) |-> perf_count_pulse == ($past(perf_event_valid) &&
    (!$past(perf_event_secure) || $past(secure_perf_count_enable))))
    else $error("perf pulse wrong");
  a_fetch_needs_guard: assert property (
    fetch_perm_fault |-> $past(secure_fetch_guard)) else $error("fetch fault without guard");
  a_gs_open: assert property (
    gs_check_valid && (gs_check_secure || !global_space_secure_only)
    |=> gs_check_done && gs_check_allow) else $error("global space access refused");
  a_ns_read_refused: assert property (
    arvalid && arready && arprot[1] && araddr[5:4] == 2'h0 && araddr[1:0] == 2'h0
    |=> rvalid && rresp == 2'h2) else $error("nonsecure read not refused");
  a_irq_ovr_width: assert property (
    (nonsecure_irq_count_override & ~IRQ_OVR_IMPL) == 8'h00) else $error("override bits set");
  c_ext_secure: cover property (ext_fault_to_secure);
  c_fetch_fault: cover property (fetch_perm_fault);
  c_gs_denied: cover property (gs_check_done && !gs_check_allow);
endmodule // stcr_asserts

bind stcr_top stcr_asserts #(.IRQ_OVR_IMPL(IRQ_OVR_IMPL)) u_asserts (.*);

/* File: tb/tb_secure_top_config_register.sv */
// Self-checking bench for the secure top configuration register
module tb_secure_top_config_register;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = '0, aresetn = '0, awvalid = '0, wvalid = '0, bready = '1, arvalid = '0;
  logic rready = '1, awready, wready, bvalid, arready, rvalid, irq;
  logic [5:0] awaddr = '0, araddr = '0;
  logic [2:0] awprot = '0, arprot = '0;
  logic [31:0] wdata = '0, rdata, got, s, rnd = 32'h00001b2f, cfg_sh = 32'h00100000;
  logic [3:0] wstrb = '0;
  logic [1:0] bresp, rresp, resp, red_sh = '0;
  logic [6:0] stat_sh = '0, ev;
  logic [12:0] ev_in = '0;
  logic [11:0] gs_check_offset = '0;
  logic [7:0] nonsecure_irq_count_override;
  logic compressed_index_secure_owner, cfg_fault_route_nonsecure, secure_perf_count_enable;
  logic secure_fetch_guard, external_fault_force_secure, global_space_secure_only, f;
  logic cfg_fault_to_secure, cfg_fault_to_nonsecure, cfg_fault_to_shared, perf_count_pulse;
  logic ext_fault_to_shared, ext_fault_to_secure, gs_check_done, gs_check_allow;
  logic fetch_perm_fault, fetch_fault_to_cb, fetch_fault_to_secure;
  wire cfg_fault_valid, cfg_fault_target_secure, ext_fault_valid, fetch_valid;
  wire fetch_secure_domain, fetch_instr, fetch_out_nonsecure, fetch_has_cb;
  wire perf_event_valid, perf_event_secure, gs_check_valid, gs_check_secure, gs_check_s2_cb;
  int err_count = 0, checks = 0, cycles = 0;
  assign {gs_check_s2_cb, gs_check_secure, gs_check_valid, perf_event_secure, perf_event_valid,
    fetch_has_cb, fetch_out_nonsecure, fetch_instr, fetch_secure_domain, fetch_valid,
    ext_fault_valid, cfg_fault_target_secure, cfg_fault_valid} = ev_in;
  stcr_top dut (.*);
  initial forever #20 aclk = ~aclk;
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] o, d, input logic [3:0] st);
    for (int i = 0; i < 4; i++) if (st[i]) o[8*i+:8] = d[8*i+:8];
    return o;
  endfunction
  // Status bits {shared, nonsecure, secure} of a config fault
  function automatic logic [2:0] cfg_route(input logic tgt);
    if (!tgt || cfg_sh[28]) return 3'h2;
    return red_sh[0] ? 3'h4 : 3'h1;
  endfunction
  task automatic chk_word(input string n, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, g);
    chk_word(n, {31'h0, e}, {31'h0, g});
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] st,
                    input logic [2:0] p);
    logic aw_hs, w_hs, b_hs;
    aw_hs = 0;
    w_hs = 0;
    b_hs = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= st;
    awprot <= p;
    awvalid <= 1;
    wvalid <= 1;
    while (!(aw_hs && w_hs)) begin
      @(negedge aclk);
      aw_hs = aw_hs || awready;
      w_hs = w_hs || wready;
      @(posedge aclk);
      if (aw_hs) awvalid <= 0;
      if (w_hs) wvalid <= 0;
    end
    while (!b_hs) begin
      @(negedge aclk);
      b_hs = bvalid;
      resp = bresp;
      @(posedge aclk);
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [2:0] p);
    logic hs;
    hs = 0;
    araddr <= a;
    arprot <= p;
    arvalid <= 1;
    while (!hs) begin
      @(negedge aclk);
      hs = arready;
      @(posedge aclk);
    end
    arvalid <= 0;
    hs = 0;
    while (!hs) begin
      @(negedge aclk);
      hs = rvalid;
      got = rdata;
      resp = rresp;
      @(posedge aclk);
    end
  endtask
  task automatic wr_cfg(input logic [31:0] d, input logic [3:0] st);
    logic [31:0] lv;
    wr(6'h00, d, st, 3'h0);
    cfg_sh = merge(cfg_sh, d, st) & 32'h3f1f0000;
    lv = {18'h0, compressed_index_secure_owner, cfg_fault_route_nonsecure,
      secure_perf_count_enable, secure_fetch_guard, external_fault_force_secure,
      global_space_secure_only, nonsecure_irq_count_override};
    chk_word("config levels", {18'h0, cfg_sh[29:16]}, lv);
  endtask
  task automatic wrap_up;
    $display("checks %0d, errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 6000) begin
      err_count++;
      wrap_up();
    end
  end
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(6'h00, 3'h0);
    chk_word("config reset", 32'h00100000, got);
    rd(6'h10, 3'h0);
    chk_word("unmapped read", 32'hc0000000, {resp, got[29:0]});
    wr(6'h14, 32'hffffffff, 4'hf, 3'h0);
    chk_word("unmapped write", 32'h3, {30'h0, resp});
    wr_cfg(32'hffffffff, 4'hf);
    rd(6'h00, 3'h0);
    chk_word("config readback", 32'h3f1f0000, got);
    rd(6'h00, 3'h2);
    chk_word("nonsecure read", 32'h80000000, {resp, got[29:0]});
    stat_sh = stat_sh | {4'h0, cfg_route(1'b1)};
    wr(6'h00, 32'h0, 4'hf, 3'h2);
    chk_word("nonsecure write", 32'h2, {30'h0, resp});
    stat_sh = stat_sh | {4'h0, cfg_route(1'b1)};
    for (int it = 0; it < 240; it++) begin
      rnd = lfsr(rnd);
      s = rnd;
      if (it % 8 == 0) begin
        rnd = lfsr(rnd);
        if (s[0]) wr_cfg(rnd, s[7:4]);
        else begin
          wr(6'h0c, rnd, 4'hf, 3'h0);
          red_sh = rnd[1:0];
        end
      end else begin
        ev_in <= s[12:0] | {7'h0, s[17:16], 4'h0};
        gs_check_offset <= s[31:20];
        @(posedge aclk);
        ev_in <= '0;
        @(negedge aclk);
        s[5:4] = s[5:4] | s[17:16];
        f = s[3] & cfg_sh[26] & s[4] & s[5] & s[6];
        ev[2:0] = s[0] ? cfg_route(s[1]) : 3'h0;
        ev[4:3] = s[2] ? ((cfg_sh[25] | red_sh[1]) ? 2'h2 : 2'h1) : 2'h0;
        ev[6:5] = {f & !s[7], f & s[7]};
        stat_sh = stat_sh | ev;
        chk_word("fault routing", {24'h0, f, ev}, {24'h0, fetch_perm_fault, fetch_fault_to_secure,
          fetch_fault_to_cb, ext_fault_to_secure, ext_fault_to_shared, cfg_fault_to_shared,
          cfg_fault_to_nonsecure, cfg_fault_to_secure});
        chk_bit("perf pulse", s[8] & (!s[9] | cfg_sh[27]), perf_count_pulse);
        chk_bit("gs allow", s[10] & (s[11] | !cfg_sh[24]), gs_check_allow);
        chk_bit("gs done", s[10], gs_check_done);
        chk_bit("irq masked", 1'b0, irq);
        @(posedge aclk);
      end
    end
    rd(6'h04, 3'h0);
    chk_word("event status", {25'h0, stat_sh}, got);
    wr(6'h08, 32'h7f, 4'hf, 3'h0);
    chk_bit("irq unmasked", |stat_sh, irq);
    wr(6'h04, {25'h0, stat_sh & 7'h55}, 4'hf, 3'h0);
    stat_sh = stat_sh & 7'h2a;
    rd(6'h04, 3'h0);
    chk_word("status after clear", {25'h0, stat_sh}, got);
    chk_bit("irq partial", |stat_sh, irq);
    wr(6'h04, 32'h7f, 4'hf, 3'h0);
    chk_bit("irq cleared", 1'b0, irq);
    wrap_up();
  end
endmodule // tb_secure_top_config_register
